// >>> core/ld_dec_pkg.sv
// ld_dec_pkg: opcodes, field codes, reset values, types and helpers
// shared by the load instruction decoder and its register bank.
// assumes a byte-wide external memory answering one cycle after a request.
package ld_dec_pkg;

  // ----------------------------------------------------------------
  // opcode bytes and field patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] PFX_IDX_X = 8'hdd;
  localparam logic [7:0] PFX_IDX_Y = 8'hfd;
  localparam logic [7:0] PFX_EXT = 8'hed;
  localparam logic [7:0] OPC_WIDE_DIR = 8'h2a;
  localparam logic [7:0] OPC_IMM_MEM = 8'h36;
  localparam logic [7:0] OPC_BREAK = 8'h64;
  localparam logic [7:0] OPC_EXT_IV = 8'h47;
  localparam logic [1:0] GRP_IMM = 2'h0;
  localparam logic [1:0] GRP_MOVE = 2'h1;
  localparam logic [3:0] EXT_WIDE_LOW = 4'hb;
  localparam logic [2:0] REG_MEM_CODE = 3'h6;
  localparam logic [2:0] REG_ACC_CODE = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WD_FIRST = 3'h0, WD_SECOND = 3'h1, WD_THIRD = 3'h2,
    WD_STACK = 3'h3, WD_IDX_X = 3'h4, WD_IDX_Y = 3'h5
  } wide_dest_e;

  typedef struct packed {
    logic [7:0] b, c, d, e, h, l, a, f, iv;
    logic [15:0] sp, ix, iy;
  } regs_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic byte_en;
    logic [2:0] byte_code;
    logic [7:0] byte_data;
    logic pair_en;
    wide_dest_e pair_sel;
    logic [15:0] pair_data;
    logic iv_en;
  } rf_wr_s;

  // byte register by its three-bit code; the memory code reads zero
  function automatic logic [7:0] read_reg(regs_s r, logic [2:0] code);
    case (code)
      3'h0: return r.b;
      3'h1: return r.c;
      3'h2: return r.d;
      3'h3: return r.e;
      3'h4: return r.h;
      3'h5: return r.l;
      3'h7: return r.a;
      default: return BYTE_RESET;
    endcase
  endfunction

  // sixteen-bit register by its destination code
  function automatic logic [15:0] read_pair(regs_s r, wide_dest_e sel);
    case (sel)
      WD_FIRST: return {r.b, r.c};
      WD_SECOND: return {r.d, r.e};
      WD_THIRD: return {r.h, r.l};
      WD_STACK: return r.sp;
      WD_IDX_X: return r.ix;
      WD_IDX_Y: return r.iy;
      default: return WORD_RESET;
    endcase
  endfunction

endpackage

// >>> core/load_reg_bank.sv
// load_reg_bank: byte registers, pairs, stack pointer, index registers,
// interrupt vector and flags of the load decoder.
// assumes one write request per cycle from the decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
module load_reg_bank
  import ld_dec_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // write requests
  input wire rf_wr_s wr,
  // register contents
  output regs_s regs
);

  logic [7:0] gp_reg [0:6];
  logic [7:0] gp_next [0:6];
  logic [15:0] sp_reg, ix_reg, iy_reg, sp_next, ix_next, iy_next;
  logic [7:0] iv_reg, iv_next, f_reg;

  // ----------------------------------------------------------------
  // byte registers, one entry per code except 110; the accumulator sits in slot 6
  // ----------------------------------------------------------------
  generate
    for (genvar k = 0; k < 7; k++) begin : g_gp
      localparam logic [2:0] CODE = (k == 6) ? REG_ACC_CODE : 3'(k);
      localparam logic [2:0] PSEL = 3'(k / 2);
      always_comb begin
        gp_next[k] = gp_reg[k];
        if (wr.byte_en && wr.byte_code == CODE) begin
          gp_next[k] = wr.byte_data;
        end else if (k < 6 && wr.pair_en && wr.pair_sel == wide_dest_e'(PSEL)) begin
          gp_next[k] = (k % 2 == 0) ? wr.pair_data[15:8] : wr.pair_data[7:0];
        end
      end
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          gp_reg[k] <= BYTE_RESET;
        end else if (clk_en) begin
          gp_reg[k] <= gp_next[k];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // wide registers and interrupt vector
  // ----------------------------------------------------------------
  always_comb begin
    sp_next = (wr.pair_en && wr.pair_sel == WD_STACK) ? wr.pair_data : sp_reg;
    ix_next = (wr.pair_en && wr.pair_sel == WD_IDX_X) ? wr.pair_data : ix_reg;
    iy_next = (wr.pair_en && wr.pair_sel == WD_IDX_Y) ? wr.pair_data : iy_reg;
    iv_next = wr.iv_en ? gp_reg[6] : iv_reg;
  end

  // flags have no write path: loads never touch them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sp_reg <= WORD_RESET;
      ix_reg <= WORD_RESET;
      iy_reg <= WORD_RESET;
      iv_reg <= BYTE_RESET;
      f_reg <= FLAG_RESET;
    end else if (clk_en) begin
      sp_reg <= sp_next;
      ix_reg <= ix_next;
      iy_reg <= iy_next;
      iv_reg <= iv_next;
      f_reg <= f_reg;
    end
  end

  // contents seen by the decoder and the outside
  assign regs = '{b: gp_reg[0], c: gp_reg[1], d: gp_reg[2], e: gp_reg[3],
                  h: gp_reg[4], l: gp_reg[5], a: gp_reg[6], f: f_reg,
                  iv: iv_reg, sp: sp_reg, ix: ix_reg, iy: iy_reg};

endmodule // load_reg_bank
`default_nettype wire

// >>> core/load_instruction_decoder.sv
// load_instruction_decoder: fetch, decode and execute of load instructions.
// assumes external memory returns read data in the cycle after the request
// is seen, and takes a write in the cycle the request is seen.
//
// Summary of operation
// - direct wide load: byte at address to low half, next byte to high half
// - first address operand is low byte, second is high byte
// - wide load targets all pairs, stack, both index regs; 3 or 4 bytes
// - two-bit pair field: 00 first, 01 second, 10 third, 11 stack
// - no load instruction changes any flag bit
// - accumulator copied into the interrupt vector register, flags kept
// - immediate byte goes to register, pointer-pair memory or indexed memory
// - register codes 000..101 name b..l, 111 the accumulator, 110 none
// - immediate-to-memory form writes at the pointer pair address
// - indexed immediate: displacement fetched before data; 4 bytes
// - register store goes to register, pointer memory or indexed memory
// - register move decodes separate destination and source fields
// - moving h into h is a breakpoint, not a load
`timescale 1ns/1ps
`default_nettype none
module load_instruction_decoder
  import ld_dec_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // external memory
  output mem_req_s mem,
  input wire logic [7:0] mem_rdata,
  // status
  output regs_s regs,
  output logic [15:0] pc,
  output logic done_pulse,
  output logic brk_pulse,
  output logic unsup_pulse
);

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH = 3'h0, ST_RWAIT = 3'h1, ST_RTAKE = 3'h2,
    ST_EXEC = 3'h3, ST_WWAIT = 3'h4
  } st_e;

  typedef enum logic [2:0] {
    T_OPC = 3'h0, T_OP0 = 3'h1, T_OP1 = 3'h2, T_MLO = 3'h3, T_MHI = 3'h4
  } tgt_e;

  typedef enum logic [1:0] {
    P_NONE = 2'h0, P_X = 2'h1, P_Y = 2'h2, P_EXT = 2'h3
  } pfx_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_WIDE_DIR = 4'h1, K_IV = 4'h2, K_IMM_REG = 4'h3,
    K_IMM_PTR = 4'h4, K_IMM_IDX = 4'h5, K_MOVE_REG = 4'h6,
    K_MOVE_PTR = 4'h7, K_MOVE_IDX = 4'h8, K_BRK = 4'h9
  } op_kind_e;

  st_e state_reg, state_next;
  tgt_e tgt_reg, tgt_next;
  pfx_e pfx_reg, pfx_next;
  op_kind_e kind_reg, kind_next;
  wide_dest_e wdest_reg, wdest_next;
  logic [15:0] pc_reg, pc_next;
  logic [2:0] code_a_reg, code_a_next, code_b_reg, code_b_next;
  logic [7:0] opnd0_reg, opnd0_next, opnd1_reg, opnd1_next;
  logic [7:0] data_lo_reg, data_lo_next;
  mem_req_s mem_reg, mem_next;
  logic done_reg, done_next, brk_reg, brk_next, unsup_reg, unsup_next;
  rf_wr_s rf_wr;
  logic [15:0] idx_addr;

  // register bank
  load_reg_bank u_bank (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .wr(rf_wr),
    .regs(regs)
  );

  // index register plus sign-extended displacement
  always_comb begin
    idx_addr = read_pair(regs, (pfx_reg == P_Y) ? WD_IDX_Y : WD_IDX_X)
             + {{8{opnd0_reg[7]}}, opnd0_reg};
  end

  // ----------------------------------------------------------------
  // sequencer: next values
  // ----------------------------------------------------------------
  always_comb begin
    logic iss;
    logic [15:0] iss_addr;
    tgt_e iss_tgt;
    op_kind_e kd;
    iss = 1'b0;
    iss_addr = pc_reg;
    iss_tgt = T_OPC;
    kd = K_NONE;
    state_next = state_reg;
    tgt_next = tgt_reg;
    pfx_next = pfx_reg;
    kind_next = kind_reg;
    wdest_next = wdest_reg;
    pc_next = pc_reg;
    code_a_next = code_a_reg;
    code_b_next = code_b_reg;
    opnd0_next = opnd0_reg;
    opnd1_next = opnd1_reg;
    data_lo_next = data_lo_reg;
    mem_next = '0;
    rf_wr = '0;
    done_next = 1'b0;
    brk_next = 1'b0;
    unsup_next = 1'b0;
    case (state_reg)
      ST_FETCH: begin
        pfx_next = P_NONE;
        iss = 1'b1;
        iss_tgt = T_OPC;
        pc_next = pc_reg + 16'h0001;
      end
      ST_RWAIT: begin
        state_next = ST_RTAKE;
      end
      ST_RTAKE: begin
        case (tgt_reg)
          T_OPC: begin
            if (pfx_reg == P_NONE && (mem_rdata == PFX_IDX_X || mem_rdata == PFX_IDX_Y
                || mem_rdata == PFX_EXT)) begin
              // prefix: remember it and fetch the real opcode
              pfx_next = (mem_rdata == PFX_IDX_X) ? P_X : (mem_rdata == PFX_IDX_Y) ? P_Y : P_EXT;
              iss = 1'b1;
              iss_tgt = T_OPC;
              pc_next = pc_reg + 16'h0001;
            end else begin
              code_a_next = mem_rdata[5:3];
              code_b_next = mem_rdata[2:0];
              case (pfx_reg)
                P_NONE: begin
                  if (mem_rdata == OPC_WIDE_DIR) begin
                    kd = K_WIDE_DIR;
                    wdest_next = WD_THIRD;
                  end else if (mem_rdata[7:6] == GRP_IMM && mem_rdata[2:0] == REG_MEM_CODE) begin
                    kd = (mem_rdata[5:3] == REG_MEM_CODE) ? K_IMM_PTR : K_IMM_REG;
                  end else if (mem_rdata[7:6] == GRP_MOVE) begin
                    if (mem_rdata == OPC_BREAK) begin
                      kd = K_BRK;
                    end else if (mem_rdata[2:0] == REG_MEM_CODE) begin
                      kd = K_NONE;
                    end else if (mem_rdata[5:3] == REG_MEM_CODE) begin
                      kd = K_MOVE_PTR;
                    end else begin
                      kd = K_MOVE_REG;
                    end
                  end
                end
                P_X, P_Y: begin
                  if (mem_rdata == OPC_WIDE_DIR) begin
                    kd = K_WIDE_DIR;
                    wdest_next = (pfx_reg == P_Y) ? WD_IDX_Y : WD_IDX_X;
                  end else if (mem_rdata == OPC_IMM_MEM) begin
                    kd = K_IMM_IDX;
                  end else if (mem_rdata[7:6] == GRP_MOVE && mem_rdata[5:3] == REG_MEM_CODE
                      && mem_rdata[2:0] != REG_MEM_CODE) begin
                    kd = K_MOVE_IDX;
                  end
                end
                default: begin
                  if (mem_rdata == OPC_EXT_IV) begin
                    kd = K_IV;
                  end else if (mem_rdata[7:6] == GRP_MOVE && mem_rdata[3:0] == EXT_WIDE_LOW) begin
                    kd = K_WIDE_DIR;
                    wdest_next = wide_dest_e'({1'b0, mem_rdata[5:4]});
                  end
                end
              endcase
              kind_next = kd;
              if (kd == K_WIDE_DIR || kd == K_IMM_IDX || kd == K_IMM_REG
                  || kd == K_IMM_PTR || kd == K_MOVE_IDX) begin
                iss = 1'b1;
                iss_tgt = T_OP0;
                pc_next = pc_reg + 16'h0001;
              end else begin
                state_next = ST_EXEC;
              end
            end
          end
          T_OP0: begin
            // first operand: address low byte, displacement or immediate
            opnd0_next = mem_rdata;
            if (kind_reg == K_WIDE_DIR || kind_reg == K_IMM_IDX) begin
              iss = 1'b1;
              iss_tgt = T_OP1;
              pc_next = pc_reg + 16'h0001;
            end else begin
              state_next = ST_EXEC;
            end
          end
          T_OP1: begin
            opnd1_next = mem_rdata;
            if (kind_reg == K_WIDE_DIR) begin
              iss = 1'b1;
              iss_tgt = T_MLO;
              iss_addr = {mem_rdata, opnd0_reg};
            end else begin
              state_next = ST_EXEC;
            end
          end
          T_MLO: begin
            data_lo_next = mem_rdata;
            iss = 1'b1;
            iss_tgt = T_MHI;
            iss_addr = {opnd1_reg, opnd0_reg} + 16'h0001;
          end
          T_MHI: begin
            rf_wr.pair_en = 1'b1;
            rf_wr.pair_sel = wdest_reg;
            rf_wr.pair_data = {mem_rdata, data_lo_reg};
            done_next = 1'b1;
            state_next = ST_FETCH;
          end
          default: begin
            state_next = ST_FETCH;
          end
        endcase
      end
      ST_EXEC: begin
        done_next = 1'b1;
        state_next = ST_FETCH;
        case (kind_reg)
          K_IV: begin
            rf_wr.iv_en = 1'b1;
          end
          K_IMM_REG: begin
            rf_wr.byte_en = 1'b1;
            rf_wr.byte_code = code_a_reg;
            rf_wr.byte_data = opnd0_reg;
          end
          K_MOVE_REG: begin
            rf_wr.byte_en = 1'b1;
            rf_wr.byte_code = code_a_reg;
            rf_wr.byte_data = read_reg(regs, code_b_reg);
          end
          K_IMM_PTR, K_MOVE_PTR: begin
            mem_next.wr = 1'b1;
            mem_next.addr = read_pair(regs, WD_THIRD);
            mem_next.wdata = (kind_reg == K_IMM_PTR) ? opnd0_reg : read_reg(regs, code_b_reg);
            state_next = ST_WWAIT;
          end
          K_IMM_IDX, K_MOVE_IDX: begin
            mem_next.wr = 1'b1;
            mem_next.addr = idx_addr;
            mem_next.wdata = (kind_reg == K_IMM_IDX) ? opnd1_reg : read_reg(regs, code_b_reg);
            state_next = ST_WWAIT;
          end
          K_BRK: begin
            brk_next = 1'b1;
          end
          default: begin
            unsup_next = 1'b1;
          end
        endcase
      end
      ST_WWAIT: begin
        state_next = ST_FETCH;
      end
      default: begin
        state_next = ST_FETCH;
      end
    endcase
    if (iss) begin
      mem_next.rd = 1'b1;
      mem_next.addr = iss_addr;
      tgt_next = iss_tgt;
      state_next = ST_RWAIT;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_FETCH;
      tgt_reg <= T_OPC;
      pfx_reg <= P_NONE;
      kind_reg <= K_NONE;
      wdest_reg <= WD_FIRST;
      pc_reg <= PC_RESET;
      code_a_reg <= 3'h0;
      code_b_reg <= 3'h0;
      opnd0_reg <= BYTE_RESET;
      opnd1_reg <= BYTE_RESET;
      data_lo_reg <= BYTE_RESET;
      mem_reg <= '0;
      done_reg <= 1'b0;
      brk_reg <= 1'b0;
      unsup_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      pfx_reg <= pfx_next;
      kind_reg <= kind_next;
      wdest_reg <= wdest_next;
      pc_reg <= pc_next;
      code_a_reg <= code_a_next;
      code_b_reg <= code_b_next;
      opnd0_reg <= opnd0_next;
      opnd1_reg <= opnd1_next;
      data_lo_reg <= data_lo_next;
      mem_reg <= mem_next;
      done_reg <= done_next;
      brk_reg <= brk_next;
      unsup_reg <= unsup_next;
    end
  end

  // outputs straight from flops
  assign mem = mem_reg;
  assign pc = pc_reg;
  assign done_pulse = done_reg;
  assign brk_pulse = brk_reg;
  assign unsup_pulse = unsup_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_exec(op_kind_e k);
    state_reg == ST_EXEC && kind_reg == k && clk_en;
  endsequence

  sequence s_take(tgt_e t);
    state_reg == ST_RTAKE && tgt_reg == t && clk_en;
  endsequence

  a_wide_low_addr: assert property (s_take(T_OP1) ##0 kind_reg == K_WIDE_DIR
    |=> mem_reg.rd && mem_reg.addr == {$past(mem_rdata), $past(opnd0_reg)})
    else $error("direct address bytes swapped");
  a_wide_next_addr: assert property (s_take(T_MLO)
    |=> mem_reg.rd && mem_reg.addr == {opnd1_reg, opnd0_reg} + 16'h0001)
    else $error("high byte not read from next address");
  a_wide_result: assert property (s_take(T_MHI)
    |=> read_pair(regs, wdest_reg) == {$past(mem_rdata), $past(data_lo_reg)} && done_pulse)
    else $error("wide load result wrong");
  a_pair_field: assert property (s_take(T_OPC) ##0 pfx_reg == P_EXT && mem_rdata[7:6] == GRP_MOVE
    && mem_rdata[3:0] == EXT_WIDE_LOW |=> kind_reg == K_WIDE_DIR
    && wdest_reg == wide_dest_e'({1'b0, $past(mem_rdata[5:4])}))
    else $error("pair select field misdecoded");
  a_flags_fixed: assert property (1'b1 |=> regs.f == $past(regs.f))
    else $error("flags changed by a load");
  a_iv_copy: assert property (s_exec(K_IV) |=> regs.iv == $past(regs.a))
    else $error("interrupt vector not loaded from accumulator");
  a_imm_reg: assert property (s_exec(K_IMM_REG)
    |=> read_reg(regs, $past(code_a_reg)) == $past(opnd0_reg))
    else $error("immediate byte not in register");
  a_ptr_store: assert property (s_exec(K_IMM_PTR) |=> mem_reg.wr
    && mem_reg.addr == $past({regs.h, regs.l}) && mem_reg.wdata == $past(opnd0_reg))
    else $error("pointer store wrong");
  a_idx_store: assert property (s_exec(K_IMM_IDX) |=> mem_reg.wr && mem_reg.wdata == $past(opnd1_reg)
    && mem_reg.addr == $past((pfx_reg == P_Y) ? regs.iy : regs.ix)
    + {{8{$past(opnd0_reg[7])}}, $past(opnd0_reg)})
    else $error("indexed store wrong");
  a_move_reg: assert property (s_exec(K_MOVE_REG)
    |=> read_reg(regs, $past(code_a_reg)) == $past(read_reg(regs, code_b_reg)))
    else $error("register move wrong");
  a_brk_hold: assert property (s_exec(K_BRK) |=> brk_pulse && regs == $past(regs))
    else $error("breakpoint changed registers");

endmodule // load_instruction_decoder
`default_nettype wire

// >>> tb/ld_mem_model.sv
// ld_mem_model: byte-wide program and data memory facing the load decoder.
// assumes the decoder's request stands one enabled cycle and read data is
// taken one enabled cycle later; the bench fills the array before reset.
`timescale 1ns/1ps
`default_nettype none
module ld_mem_model
  import ld_dec_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // request and answer
  input wire mem_req_s mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [0:65535];

  // ----------------------------------------------------------------
  // answer reads next cycle, take writes at once
  // ----------------------------------------------------------------
  // outside an answer cycle the data line toggles so stale data never matches
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= 8'h5a;
    end else if (clk_en) begin
      if (mem.rd) begin
        mem_rdata <= store[mem.addr];
      end else begin
        mem_rdata <= ~mem_rdata;
      end
      if (mem.wr) begin
        store[mem.addr] <= mem.wdata;
      end
    end
  end
endmodule // ld_mem_model
`default_nettype wire

// >>> tb/load_instruction_decoder_tb.sv
// load_instruction_decoder_tb: random load programs with a fixed seed,
// checked against a bench model of registers and memory writes.
// assumes data bytes all have bit 7 set so every pointer stays above code.
`timescale 1ns/1ps
`default_nettype none
module load_instruction_decoder_tb
  import ld_dec_pkg::*;
;
  localparam int NI = 80;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  mem_req_s mem;
  logic [7:0] mem_rdata;
  regs_s regs;
  logic done_pulse, brk_pulse, unsup_pulse;
  logic [15:0] pc;
  integer seed = 32'h5ddb;
  int error_cnt = 0;
  int total_checks = 0;
  int n_done = 0;
  logic [7:0] ref_mem [0:65535];
  regs_s exp_q [$];
  logic [1:0] brk_q [$];
  logic [15:0] pc_q [$];
  logic [23:0] wr_q [$];
  regs_s er;
  logic [15:0] gpc = 16'h0000;

  // ----------------------------------------------------------------
  // clock, enable and instances
  // ----------------------------------------------------------------
  always #50 mclk = ~mclk;
  // enable stalls the core at random, about a quarter of the time
  always @(negedge mclk) clk_en <= (($random(seed) & 3) != 0);

  load_instruction_decoder i_load_instruction_decoder (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .mem(mem),
    .mem_rdata(mem_rdata), .regs(regs), .pc(pc), .done_pulse(done_pulse), .brk_pulse(brk_pulse),
    .unsup_pulse(unsup_pulse));
  ld_mem_model i_ld_mem_model (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .mem(mem), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // bench model helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  function automatic regs_s put_reg(regs_s r, logic [2:0] c, logic [7:0] v);
    case (c)
      3'h0: r.b = v;
      3'h1: r.c = v;
      3'h2: r.d = v;
      3'h3: r.e = v;
      3'h4: r.h = v;
      3'h5: r.l = v;
      default: r.a = v;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] get_reg(regs_s r, logic [2:0] c);
    logic [7:0] t [0:7];
    t = '{r.b, r.c, r.d, r.e, r.h, r.l, 8'h00, r.a};
    return t[c];
  endfunction

  function automatic regs_s put_pair(regs_s r, logic [2:0] s, logic [15:0] v);
    case (s)
      3'h0: {r.b, r.c} = v;
      3'h1: {r.d, r.e} = v;
      3'h2: {r.h, r.l} = v;
      3'h3: r.sp = v;
      3'h4: r.ix = v;
      default: r.iy = v;
    endcase
    return r;
  endfunction

  task automatic emit(input logic [7:0] v);
    ref_mem[gpc] = v;
    i_ld_mem_model.store[gpc] = v;
    gpc++;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    wr_q.push_back({a, v});
    ref_mem[a] = v;
  endtask

  // ----------------------------------------------------------------
  // program generator: one instruction and its expected effect
  // ----------------------------------------------------------------
  // first six fill every pair and index reg, the seventh the accumulator
  task automatic gen(input int k);
    int kind;
    logic [7:0] x, d, n;
    logic [2:0] s, t, sel;
    logic [15:0] a, ix;
    logic [1:0] brk;
    kind = (k < 6) ? 0 : (k == 6) ? 2 : $unsigned($random(seed)) % 9;
    x = 8'($random(seed));
    d = (k % 5 == 0) ? 8'h80 : (k % 7 == 0) ? 8'h7f : 8'($random(seed));
    n = 8'($random(seed)) | 8'h80;
    s = (k == 6) ? REG_ACC_CODE : 3'($random(seed));
    t = 3'($random(seed));
    if (s == REG_MEM_CODE) s = REG_ACC_CODE;
    if (t == REG_MEM_CODE) t = 3'h0;
    sel = (k < 6) ? 3'(k) : 3'($unsigned($random(seed)) % 6);
    a = {8'h80 | (8'($random(seed)) & 8'h7e), 8'($random(seed))};
    ix = (x[0] ? er.iy : er.ix) + {{8{d[7]}}, d};
    brk = 2'b00;
    case (kind)
      0: begin
        if (sel == WD_IDX_X) emit(PFX_IDX_X);
        if (sel == WD_IDX_Y) emit(PFX_IDX_Y);
        if (sel < 3'h4 && !(sel == WD_THIRD && x[1])) emit(PFX_EXT);
        emit((sel < 3'h4 && !(sel == WD_THIRD && x[1])) ? {GRP_MOVE, sel[1:0], EXT_WIDE_LOW} : OPC_WIDE_DIR);
        emit(a[7:0]);
        emit(a[15:8]);
        er = put_pair(er, sel, {ref_mem[a + 16'h0001], ref_mem[a]});
      end
      1: begin
        emit(PFX_EXT);
        emit(OPC_EXT_IV);
        er.iv = er.a;
      end
      2: begin
        emit({GRP_IMM, s, REG_MEM_CODE});
        emit(n);
        er = put_reg(er, s, n);
      end
      3: begin
        emit(OPC_IMM_MEM);
        emit(n);
        wr({er.h, er.l}, n);
      end
      4: begin
        emit(x[0] ? PFX_IDX_Y : PFX_IDX_X);
        emit(OPC_IMM_MEM);
        emit(d);
        emit(n);
        wr(ix, n);
      end
      5: begin
        if (s == 3'h4 && t == 3'h4) t = 3'h5;
        emit({GRP_MOVE, s, t});
        er = put_reg(er, s, get_reg(er, t));
      end
      6: begin
        emit({GRP_MOVE, REG_MEM_CODE, t});
        wr({er.h, er.l}, get_reg(er, t));
      end
      7: begin
        emit(x[0] ? PFX_IDX_Y : PFX_IDX_X);
        emit({GRP_MOVE, REG_MEM_CODE, t});
        emit(d);
        wr(ix, get_reg(er, t));
      end
      default: begin
        // a load from memory into a register is outside the set and skipped
        if (x[2]) begin
          emit({GRP_MOVE, t, REG_MEM_CODE});
          brk = 2'b01;
        end else begin
          emit(OPC_BREAK);
          brk = 2'b10;
        end
      end
    endcase
    exp_q.push_back(er);
    brk_q.push_back(brk);
    pc_q.push_back(gpc);
  endtask

  // ----------------------------------------------------------------
  // monitors: instruction ends and memory writes
  // ----------------------------------------------------------------
  // a pulse ends at the first enabled edge after it rises, so count it there
  always @(posedge mclk) begin
    if (rst_b && clk_en && (done_pulse || brk_pulse || unsup_pulse) && n_done < NI) begin
      chk("registers", exp_q[n_done], regs);
      chk("pc", pc_q[n_done], pc);
      chk("brk and unsup pulses", brk_q[n_done], {brk_pulse, unsup_pulse});
      n_done++;
    end
    if (rst_b && clk_en && mem.wr) begin
      chk("memory write", (wr_q.size() != 0) ? wr_q.pop_front() : 24'hxxxxxx,
          {mem.addr, mem.wdata});
    end
  end

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    er = '0;
    for (int i = 0; i < 65536; i++) ref_mem[i] = (i >= 32'h7f00) ? (8'($random(seed)) | 8'h80) : 8'h00;
    // memory gets the data before the program, so expected writes stay out of it
    for (int i = 0; i < 65536; i++) i_ld_mem_model.store[i] = ref_mem[i];
    for (int k = 0; k < NI; k++) gen(k);
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst_b <= 1'b1;
    for (int w = 0; w < 20000 && n_done < NI; w++) @(posedge mclk);
    if (n_done < NI) begin
      $display("[ERR] completions expected %0d seen %0d", NI, n_done);
      error_cnt++;
    end
    chk("writes left", 128'h0, 128'(wr_q.size()));
    end_of_test();
  end
endmodule // load_instruction_decoder_tb
`default_nettype wire
